// >>> hw/flash_lock_defs.svh
/*
 * Offsets, field positions, reset values and timing counts of the flash
 * protection and non-volatile configuration block.
 * Assumes a 200 MHz system clock and a byte-addressed APB with 32-bit data.
 */
`ifndef FLASH_LOCK_DEFS_SVH
`define FLASH_LOCK_DEFS_SVH

// Register byte offsets.
`define ADDR_CMD          8'h00
`define ADDR_STATUS       8'h04
`define ADDR_LOCK         8'h08
`define ADDR_NVBITS       8'h0C

// Command register fields.
`define CMD_CODE_LSB      0
`define CMD_CODE_W        4
`define CMD_ARG_LSB       8

// Status register bit positions.
`define STAT_BUSY         0
`define STAT_DONE         1
`define STAT_LOCKERR      2
`define STAT_CMDERR       3
`define STAT_SECURE       4
`define STAT_FFPMODE      5
`define STAT_ERASEPIN     6

// Non-volatile bit register field: calibration byte position.
`define NVREG_CALIB_LSB   8

// Flash geometry of the dual-plane variant.
`define PAGE_W            11
`define REGION_W          5
`define NUM_REGIONS       32
`define PAGES_PER_REGION  11'h040
`define PAGE_BYTES        256
`define PLANE_BIT         10

// General-purpose non-volatile bits and their indices.
`define NUM_GPNV          3
`define GPNV_IDX_MAX      11'h002
`define NVB_BOD_EN        0
`define NVB_BOD_RST       1
`define NVB_BOOT          2
`define CALIB_W           8

// Reset values of the non-volatile state (erased state).
`define LOCK_RST          32'h0000_0000
`define GPNV_RST          3'h0
`define SECURE_RST        1'b0
`define CALIB_DEFAULT     8'hA5

// Timing: clock rate, printed times and derived cycle counts.
`define CNT_W             26
`define CLK_MHZ           200
`define PROG_TIME_US      6000
`define FULL_ERASE_US     15000
`define ERASE_PIN_MS      220
`define PROG_CYCLES       (`PROG_TIME_US * `CLK_MHZ)
`define FULL_ERASE_CYCLES (`FULL_ERASE_US * `CLK_MHZ)
`define ERASE_HOLD_CYCLES (`ERASE_PIN_MS * 1000 * `CLK_MHZ)

`endif

// >>> hw/flash_lock_pkg.sv
/*
 * Types shared by the flash protection block: command codes and the
 * states of the command engine.
 * Assumes nothing of its surroundings.
 */
package flash_lock_pkg;

    // Commands accepted from software and from the fast programming port.
    typedef enum logic [3:0] {
        CMD_NONE       = 4'h0,
        CMD_PROG_PAGE  = 4'h1,
        CMD_ERASE_PAGE = 4'h2,
        CMD_FULL_ERASE = 4'h3,
        CMD_SET_LOCK   = 4'h4,
        CMD_CLR_LOCK   = 4'h5,
        CMD_SET_NVB    = 4'h6,
        CMD_CLR_NVB    = 4'h7,
        CMD_SET_SECURE = 4'h8
    } flash_cmd_t;

    // Command engine states.
    typedef enum logic [1:0] {
        ENG_IDLE      = 2'b00,
        ENG_RUN       = 2'b01,
        ENG_PIN_ERASE = 2'b10
    } engine_state_t;

endpackage

// >>> hw/sync_2ff.sv
/*
 * Two flip-flop synchroniser for asynchronous level inputs.
 * Assumes the inputs change slowly compared to the clock.
 */
`timescale 1ns/10ps
module sync_2ff #(
    parameter int W = 1
) (
    // Clock and reset.
    input  wire logic         clk,
    input  wire logic         rst_n,
    // Asynchronous level in, synchronised level out.
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_reg;   // First stage, read only by the second.

    // Both stages clear under reset.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end

endmodule // sync_2ff

// >>> hw/erase_pin_filter.sv
/*
 * Qualifies the erase pin: a one-cycle pulse is given once the pin has
 * stood high for the full hold time without a break.
 * Assumes the pin level is already synchronised to clk.
 */
`timescale 1ns/10ps
`include "flash_lock_defs.svh"
module erase_pin_filter #(
    parameter int unsigned HOLD_CYCLES = `ERASE_HOLD_CYCLES
) (
    // Clock and reset.
    input  wire logic clk,
    input  wire logic rst_n,
    // Synchronised pin level and qualified event.
    input  wire logic pinLevel,
    output logic      qualifyPulse
);

    logic [`CNT_W-1:0] count_reg;     // Cycles the pin has been high.
    logic [`CNT_W-1:0] count_next;
    logic              fired_reg;     // Set after the pulse, until release.
    logic              fired_next;
    logic              pulse_next;

    // Count while high; a short press never reaches the threshold.
    always_comb begin
        count_next = count_reg;
        fired_next = fired_reg;
        pulse_next = 1'b0;
        if (!pinLevel) begin
            count_next = '0;
            fired_next = 1'b0;
        end else if (!fired_reg) begin
            if (count_reg == `CNT_W'(HOLD_CYCLES - 1)) begin
                pulse_next = 1'b1;
                fired_next = 1'b1;
            end else begin
                count_next = count_reg + `CNT_W'(1);
            end
        end
    end

    // Registers the counter and the pulse.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg    <= '0;
            fired_reg    <= 1'b0;
            qualifyPulse <= 1'b0;
        end else begin
            count_reg    <= count_next;
            fired_reg    <= fired_next;
            qualifyPulse <= pulse_next;
        end
    end

endmodule // erase_pin_filter

// >>> hw/flash_lock_ctrl.sv
/*
 * Flash protection and non-volatile configuration: lock bits for 32
 * regions, security bit, general-purpose non-volatile bits, calibration
 * bits, erase pin handling and fast programming mode entry, with an APB
 * register slave and a fast programming command port.
 * Assumes the erase, test and port A pins are asynchronous, and that the
 * fast programming decoder, debug port and CPU read path run on clk.
 */
`timescale 1ns/10ps
`include "flash_lock_defs.svh"

module flash_lock_ctrl #(
    parameter int unsigned PROG_CYCLES       = `PROG_CYCLES,
    parameter int unsigned FULL_ERASE_CYCLES = `FULL_ERASE_CYCLES,
    parameter int unsigned ERASE_HOLD_CYCLES = `ERASE_HOLD_CYCLES,
    parameter logic [`CALIB_W-1:0] CALIB_VALUE = `CALIB_DEFAULT
) (
    // Clock and reset.
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    // APB slave.
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [7:0]               paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    // Asynchronous pins.
    input  wire logic                     erasePin,
    input  wire logic                     testModePin,
    input  wire logic                     portALine0,
    input  wire logic                     portALine1,
    // Fast programming port commands and reads.
    input  wire logic                     ffpCmdValid,
    input  wire flash_lock_pkg::flash_cmd_t ffpCmdCode,
    input  wire logic [`PAGE_W-1:0]       ffpCmdArg,
    output logic                          ffpCmdReady,
    output logic                          ffpCmdRefused,
    input  wire logic                     ffpReadReq,
    output logic                          ffpReadGrant,
    // Debug port and CPU flash reads.
    input  wire logic                     debugReadReq,
    output logic                          debugReadGrant,
    input  wire logic                     cpuReadReq,
    input  wire logic                     cpuReadPlane,
    output logic                          cpuReadGrant,
    // Status and configuration outputs.
    output logic                          lockAbortEvent,
    output logic                          cmdDoneEvent,
    output logic      [1:0]               planeBusy,
    output logic                          securityActive,
    output logic                          ffpModeActive,
    output logic                          brownoutDetectorEnable,
    output logic                          brownoutResetEnable,
    output logic                          bootFromFlash,
    output logic      [`CALIB_W-1:0]      calibBits
);
    import flash_lock_pkg::*;

    // Page number to lock region index.
    function automatic logic [`REGION_W-1:0] regionOf(
        input logic [`PAGE_W-1:0] page);
        logic [`PAGE_W-1:0] quot;
        quot = page / `PAGES_PER_REGION;
        return quot[`REGION_W-1:0];
    endfunction

    // Page number to the mask of the plane that holds it.
    function automatic logic [1:0] planeOf(input logic [`PAGE_W-1:0] page);
        return page[`PLANE_BIT] ? 2'b10 : 2'b01;
    endfunction

    // Synchronised pins and erase pin qualification.
    logic [3:0] pinSync;          // Erase, test, line 0, line 1.
    logic       eraseQualified;   // One-cycle pulse after the hold time.

    sync_2ff #(.W(4)) u_pin_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     ({erasePin, testModePin, portALine0, portALine1}),
        .q     (pinSync)
    );

    erase_pin_filter #(.HOLD_CYCLES(ERASE_HOLD_CYCLES)) u_erase_filter (
        .clk          (clk),
        .rst_n        (rst_n),
        .pinLevel     (pinSync[3]),
        .qualifyPulse (eraseQualified)
    );

    // Engine and non-volatile state.
    engine_state_t             state_reg,    state_next;
    logic [`CNT_W-1:0]         count_reg,    count_next;
    logic [1:0]                busy_reg,     busy_next;
    logic [`NUM_REGIONS-1:0]   lock_reg,     lock_next;
    logic [`NUM_GPNV-1:0]      gpnv_reg,     gpnv_next;
    logic                      secure_reg,   secure_next;
    // Sticky status flags and event pulses.
    logic                      done_reg,     done_next;
    logic                      lockErr_reg,  lockErr_next;
    logic                      cmdErr_reg,   cmdErr_next;
    logic                      abort_next,   donePulse_next;
    // Port outputs that are computed each cycle.
    logic                      ffpReady_next, ffpRefused_next;
    logic                      ffpGrant_next, dbgGrant_next, cpuGrant_next;
    logic                      ffpMode_next;
    logic [31:0]               prdata_next;
    logic                      pready_next,  pslverr_next;
    // Command selection.
    logic                      apbAccess, apbWrite, apbCmd, ffpTake;
    logic                      selValid, unmapped;
    flash_cmd_t                selCode;
    logic [`PAGE_W-1:0]        selArg;
    logic [`REGION_W-1:0]      selRegion;

    // APB decode: an access completes when pready stands high.
    always_comb begin
        apbAccess = psel && penable && pready;
        apbWrite  = apbAccess && pwrite;
        apbCmd    = apbWrite && (paddr == `ADDR_CMD);
        ffpTake   = ffpCmdValid && ffpCmdReady;
        unmapped  = (paddr != `ADDR_CMD) && (paddr != `ADDR_STATUS) &&
                    (paddr != `ADDR_LOCK) && (paddr != `ADDR_NVBITS);
        selValid  = ffpTake || apbCmd;
        selCode   = ffpTake ? ffpCmdCode :
                    flash_cmd_t'(pwdata[`CMD_CODE_LSB +: `CMD_CODE_W]);
        selArg    = ffpTake ? ffpCmdArg : pwdata[`CMD_ARG_LSB +: `PAGE_W];
        selRegion = regionOf(selArg);
    end

    // Command engine, lock bits, security and non-volatile bits.
    always_comb begin
        state_next     = state_reg;
        count_next     = count_reg;
        busy_next      = busy_reg;
        lock_next      = lock_reg;
        gpnv_next      = gpnv_reg;
        secure_next    = secure_reg;
        abort_next     = 1'b0;
        donePulse_next = 1'b0;
        lockErr_next   = lockErr_reg;
        cmdErr_next    = cmdErr_reg;
        done_next      = done_reg;
        // Software clears sticky flags by writing ones; a set wins below.
        if (apbWrite && (paddr == `ADDR_STATUS)) begin
            done_next    = done_reg    & ~pwdata[`STAT_DONE];
            lockErr_next = lockErr_reg & ~pwdata[`STAT_LOCKERR];
            cmdErr_next  = cmdErr_reg  & ~pwdata[`STAT_CMDERR];
        end
        // Timed operations count down to completion.
        case (state_reg)
            ENG_IDLE: begin
                count_next = count_reg;
            end
            ENG_RUN, ENG_PIN_ERASE: begin
                if (count_reg == '0) begin
                    if (state_reg == ENG_PIN_ERASE) begin
                        secure_next = 1'b0;
                    end
                    state_next     = ENG_IDLE;
                    busy_next      = 2'b00;
                    done_next      = 1'b1;
                    donePulse_next = 1'b1;
                end else begin
                    count_next = count_reg - `CNT_W'(1);
                end
            end
            default: begin
                state_next = ENG_IDLE;
                busy_next  = 2'b00;
            end
        endcase
        // A command while busy, or two at once, is refused.
        if (selValid && (state_reg != ENG_IDLE || (ffpTake && apbCmd))) begin
            cmdErr_next = 1'b1;
        end else if (selValid) begin
            case (selCode)
                CMD_PROG_PAGE, CMD_ERASE_PAGE: begin
                    if (lock_reg[selRegion]) begin
                        abort_next   = 1'b1;
                        lockErr_next = 1'b1;
                    end else begin
                        state_next = ENG_RUN;
                        count_next = `CNT_W'(PROG_CYCLES - 1);
                        busy_next  = planeOf(selArg);
                    end
                end
                CMD_FULL_ERASE: begin
                    if (|lock_reg) begin
                        abort_next   = 1'b1;
                        lockErr_next = 1'b1;
                    end else begin
                        state_next = ENG_RUN;
                        count_next = `CNT_W'(FULL_ERASE_CYCLES - 1);
                        busy_next  = 2'b11;
                    end
                end
                CMD_SET_LOCK, CMD_CLR_LOCK: begin
                    lock_next[selRegion] = (selCode == CMD_SET_LOCK);
                    done_next            = 1'b1;
                    donePulse_next       = 1'b1;
                end
                CMD_SET_NVB, CMD_CLR_NVB: begin
                    if (selArg > `GPNV_IDX_MAX) begin
                        cmdErr_next = 1'b1;
                    end else begin
                        gpnv_next[selArg[1:0]] = (selCode == CMD_SET_NVB);
                        done_next              = 1'b1;
                        donePulse_next         = 1'b1;
                    end
                end
                CMD_SET_SECURE: begin
                    secure_next    = 1'b1;
                    done_next      = 1'b1;
                    donePulse_next = 1'b1;
                end
                default: begin
                    cmdErr_next = 1'b1;
                end
            endcase
        end
        // A qualified erase pin overrides the engine, lock and non-volatile bits and erases the flash.
        if (eraseQualified) begin
            lock_next  = `LOCK_RST;
            gpnv_next  = `GPNV_RST;
            state_next = ENG_PIN_ERASE;
            count_next = `CNT_W'(FULL_ERASE_CYCLES - 1);
            busy_next  = 2'b11;
        end
    end

    // Access grants, fast mode and APB answer.
    always_comb begin
        ffpMode_next    = pinSync[2] && pinSync[1] && pinSync[0];
        dbgGrant_next   = debugReadReq && !secure_reg;
        ffpGrant_next   = ffpReadReq && ffpModeActive && !secure_reg;
        ffpRefused_next = (ffpCmdValid || ffpReadReq) && ffpModeActive &&
                          secure_reg;
        cpuGrant_next   = cpuReadReq && !busy_reg[cpuReadPlane];
        ffpReady_next   = (state_next == ENG_IDLE) && ffpMode_next &&
                          !secure_next && !ffpTake && !apbCmd;
        // One wait state: pready rises in the second access cycle.
        pready_next     = psel && penable && !pready;
        pslverr_next    = pready_next && unmapped;
        prdata_next     = prdata;
        if (pready_next && !pwrite) begin
            prdata_next = 32'h0000_0000;
            case (paddr)
                `ADDR_STATUS: begin
                    prdata_next[`STAT_BUSY]     = (state_reg != ENG_IDLE);
                    prdata_next[`STAT_DONE]     = done_reg;
                    prdata_next[`STAT_LOCKERR]  = lockErr_reg;
                    prdata_next[`STAT_CMDERR]   = cmdErr_reg;
                    prdata_next[`STAT_SECURE]   = secure_reg;
                    prdata_next[`STAT_FFPMODE]  = ffpModeActive;
                    prdata_next[`STAT_ERASEPIN] = pinSync[3];
                end
                `ADDR_LOCK: prdata_next = lock_reg;
                `ADDR_NVBITS: begin
                    prdata_next[`NUM_GPNV-1:0] = gpnv_reg;
                    prdata_next[`NVREG_CALIB_LSB +: `CALIB_W] = CALIB_VALUE;
                end
                default: prdata_next = 32'h0000_0000;
            endcase
        end
    end

    // Registers all state and the event, grant, mode and APB outputs.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg       <= ENG_IDLE;
            count_reg       <= '0;
            busy_reg        <= 2'b00;
            lock_reg        <= `LOCK_RST;
            gpnv_reg        <= `GPNV_RST;
            secure_reg      <= `SECURE_RST;
            done_reg        <= 1'b0;
            lockErr_reg     <= 1'b0;
            cmdErr_reg      <= 1'b0;
            lockAbortEvent  <= 1'b0;
            cmdDoneEvent    <= 1'b0;
            ffpCmdReady     <= 1'b0;
            ffpCmdRefused   <= 1'b0;
            ffpReadGrant    <= 1'b0;
            debugReadGrant  <= 1'b0;
            cpuReadGrant    <= 1'b0;
            ffpModeActive   <= 1'b0;
            prdata          <= 32'h0000_0000;
            pready          <= 1'b0;
            pslverr         <= 1'b0;
        end else begin
            state_reg       <= state_next;
            count_reg       <= count_next;
            busy_reg        <= busy_next;
            lock_reg        <= lock_next;
            gpnv_reg        <= gpnv_next;
            secure_reg      <= secure_next;
            done_reg        <= done_next;
            lockErr_reg     <= lockErr_next;
            cmdErr_reg      <= cmdErr_next;
            lockAbortEvent  <= abort_next;
            cmdDoneEvent    <= donePulse_next;
            ffpCmdReady     <= ffpReady_next;
            ffpCmdRefused   <= ffpRefused_next;
            ffpReadGrant    <= ffpGrant_next;
            debugReadGrant  <= dbgGrant_next;
            cpuReadGrant    <= cpuGrant_next;
            ffpModeActive   <= ffpMode_next;
            prdata          <= prdata_next;
            pready          <= pready_next;
            pslverr         <= pslverr_next;
        end
    end

    // Configuration outputs taken straight from the state flops; calibration bits from CALIB_VALUE.
    // bit meanings
    assign brownoutDetectorEnable = gpnv_reg[`NVB_BOD_EN];
    assign brownoutResetEnable    = gpnv_reg[`NVB_BOD_RST];
    assign bootFromFlash          = gpnv_reg[`NVB_BOOT];
    assign securityActive         = secure_reg;
    assign planeBusy              = busy_reg;
    assign calibBits              = CALIB_VALUE;

endmodule // flash_lock_ctrl

// >>> dv/flash_lock_ctrl_properties.sv
/* Concurrent checks on the ports of the flash protection block.
   Assumes one clock domain and the asynchronous active-low reset. */
`timescale 1ns/10ps
module flash_lock_ctrl_checker #(
    parameter logic [7:0] CALIB_VALUE = 8'hA5
) (
    // Clock, reset, bus and pins, grouped for brevity.
    input wire logic       clk, rst_n, psel, penable, pready, pslverr,
    input wire logic [7:0] paddr, calibBits,
    input wire logic       testModePin, portALine0, portALine1,
    input wire logic       ffpCmdValid, ffpCmdReady, ffpCmdRefused,
    input wire logic       ffpReadReq, ffpReadGrant, debugReadReq,
    input wire logic       debugReadGrant, cpuReadReq, cpuReadPlane,
    input wire logic       cpuReadGrant, lockAbortEvent,
    input wire logic [1:0] planeBusy,
    input wire logic       securityActive, ffpModeActive
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // One wait cycle, then the answer.
    sequence answer_s; !pready ##1 pready; endsequence
    apb_wait_a: assert property (psel && !penable |=> answer_s) else $error("apb answer late");
    unmapped_err_a: assert property (pready |-> pslverr ==
        !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C})) else $error("bad slverr");
    debug_block_a: assert property (debugReadGrant |-> $past(debugReadReq)
        && !$past(securityActive)) else $error("debug read while secure");
    ffp_grant_a: assert property (ffpReadGrant |-> $past(ffpModeActive)
        && !$past(securityActive)) else $error("fast read while secure");
    ffp_refuse_a: assert property ((ffpCmdValid || ffpReadReq) &&
        ffpModeActive && securityActive |=> ffpCmdRefused) else $error("no refuse");
    calib_fixed_a: assert property (calibBits == CALIB_VALUE)
        else $error("calibration changed");
    abort_idle_a: assert property (lockAbortEvent |-> planeBusy == 2'b00)
        else $error("aborted command started");
    ffp_take_a: assert property (ffpCmdValid && ffpCmdReady |=> !ffpCmdReady)
        else $error("fast port ready stayed");
    fast_entry_a: assert property (ffpModeActive |->
        $past(testModePin && portALine0 && portALine1, 3)) else $error("bad mode");
    plane_read_a: assert property (cpuReadGrant |-> $past(cpuReadReq) &&
        !$past(planeBusy[cpuReadPlane])) else $error("read of busy plane");
endmodule // flash_lock_ctrl_checker
bind flash_lock_ctrl flash_lock_ctrl_checker #(.CALIB_VALUE(CALIB_VALUE))
    flash_lock_ctrl_checker_i (.clk, .rst_n, .psel, .penable, .pready,
    .pslverr, .paddr, .calibBits, .testModePin, .portALine0, .portALine1,
    .ffpCmdValid, .ffpCmdReady, .ffpCmdRefused, .ffpReadReq, .ffpReadGrant,
    .debugReadReq, .debugReadGrant, .cpuReadReq, .cpuReadPlane, .cpuReadGrant,
    .lockAbortEvent, .planeBusy, .securityActive, .ffpModeActive);

// >>> dv/ffp_programmer_model.sv
/* External programmer: mode pins, erase pin, fast port handshake.
   Assumes it shares the block clock. */
`timescale 1ns/10ps
module ffp_programmer_model (
    // Clock and handshake answer.
    input wire logic clk,
    input wire logic ffpCmdReady,
    // Pins and command request.
    output logic erasePin, testModePin, portALine0, portALine1, ffpCmdValid,
    output flash_lock_pkg::flash_cmd_t ffpCmdCode,
    output logic [10:0] ffpCmdArg
);
    import flash_lock_pkg::*;
    initial begin
        {erasePin, testModePin, portALine0, portALine1, ffpCmdValid} = '0;
        ffpCmdCode = CMD_NONE;
        ffpCmdArg = '0;
    end
    task automatic enter_fast();
        @(posedge clk);
        {testModePin, portALine0, portALine1} <= 3'b111;
    endtask
    task automatic erase_hold(input int n);
        @(posedge clk);
        erasePin <= 1'b1;
        repeat (n) @(posedge clk);
        erasePin <= 1'b0;
    endtask
    // Holds the request until taken or 50 cycles pass; released arg lines show the inverse.
    task automatic send(input flash_cmd_t c, input logic [10:0] a,
                        output logic ok);
        @(posedge clk);
        {ffpCmdValid, ffpCmdArg} <= {1'b1, a};
        ffpCmdCode <= c;
        ok = 1'b0;
        repeat (50) begin
            @(posedge clk);
            if (ffpCmdReady === 1'b1) begin
                ok = 1'b1;
                break;
            end
        end
        {ffpCmdValid, ffpCmdArg} <= {1'b0, ~a};
        ffpCmdCode <= CMD_NONE;
    endtask
endmodule // ffp_programmer_model

// >>> dv/test_flash_lock_ctrl.sv
/* Self-checking bench: APB master, read queue, fast port partner.
   Assumes a 200 MHz clock and shortened timing parameters. */
`timescale 1ns/10ps
module test_flash_lock_ctrl;
    import flash_lock_pkg::*;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, ok;
    logic [7:0] paddr, calibBits;
    logic [31:0] pwdata, prdata;
    logic erasePin, testModePin, portALine0, portALine1, ffpCmdValid;
    flash_cmd_t ffpCmdCode;
    logic [10:0] ffpCmdArg, pg;
    logic ffpCmdReady, ffpCmdRefused, ffpReadReq, ffpReadGrant;
    logic debugReadReq, debugReadGrant, cpuReadReq, cpuReadPlane;
    logic cpuReadGrant, lockAbortEvent, cmdDoneEvent, securityActive;
    logic ffpModeActive, brownoutDetectorEnable, brownoutResetEnable;
    logic bootFromFlash;
    logic [1:0] planeBusy;
    logic [32:0] expQ[$];
    int failures, totalChecks, aborts, cyc;
    flash_lock_ctrl #(.PROG_CYCLES(20), .FULL_ERASE_CYCLES(40),
        .ERASE_HOLD_CYCLES(10)) flash_lock_ctrl_i (.*);
    ffp_programmer_model ffp_programmer_model_i (.*);
    initial forever #2.5 clk = ~clk;
    task automatic chk(input logic [32:0] s, e, input string n);
        totalChecks++;
        if (s !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", totalChecks, failures);
        if (failures == 0 && totalChecks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Bus cycle; a read notes its expected slverr and data first.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [32:0] e);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        if (!w) expQ.push_back(e);
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        {psel, penable} <= 2'b00;
    endtask
    task automatic cmd(input logic [3:0] c, input logic [10:0] a);
        apb(1'b1, 8'h00, {13'h0, a, 4'h0, c}, '0);
    endtask
    task automatic waitdone();
        ok = 1'b0;
        repeat (100) begin
            @(posedge clk);
            if (cmdDoneEvent === 1'b1) begin
                ok = 1'b1;
                break;
            end
        end
        chk(ok, 1, "done event");
    endtask
    // Read results are compared against the oldest note.
    always @(posedge clk) begin
        cyc++;
        if (lockAbortEvent === 1'b1) aborts++;
        if (psel && penable && !pwrite && pready === 1'b1)
            chk({pslverr, prdata}, expQ.pop_front(), "read");
        if (cyc == 3000) begin
            failures++;
            give_verdict();
        end
    end
    initial begin
        {clk, rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        {ffpReadReq, debugReadReq, cpuReadReq, cpuReadPlane} = '0;
        void'($urandom(72412));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b1, 8'h08, 32'hFFFF_FFFF, '0);
        apb(1'b0, 8'h08, 32'h0, 33'h0);
        apb(1'b0, 8'h0C, 32'h0, 33'h0_0000_A500);
        apb(1'b0, 8'h10, 32'h0, 33'h1_0000_0000);
        $display("reset test done");
        pg = 11'($urandom);
        cmd(4'h4, pg);
        apb(1'b0, 8'h08, 32'h0, 33'(1) << pg[10:6]);
        for (int c = 1; c < 4; c++) cmd(4'(c), pg);
        repeat (3) @(posedge clk);
        chk(aborts, 3, "aborts");
        apb(1'b0, 8'h04, 32'h0, 33'h0_0000_0006);
        cmd(4'h5, pg);
        apb(1'b0, 8'h08, 32'h0, 33'h0);
        cmd(4'h1, pg);
        repeat (3) @(posedge clk);
        chk(planeBusy[pg[10]], 1, "busy plane");
        {cpuReadReq, cpuReadPlane} <= {1'b1, ~pg[10]};
        repeat (2) @(posedge clk);
        chk(cpuReadGrant, 1, "other plane");
        cpuReadReq <= 1'b0;
        waitdone();
        $display("lock test done");
        for (int i = 0; i < 3; i++) cmd(4'h6, 11'(i));
        repeat (2) @(posedge clk);
        chk({bootFromFlash, brownoutResetEnable, brownoutDetectorEnable},
            7, "nv outputs");
        cmd(4'h7, 11'h1);
        apb(1'b0, 8'h0C, 32'h0, 33'h0_0000_A505);
        $display("nv test done");
        ffp_programmer_model_i.enter_fast();
        repeat (5) @(posedge clk);
        chk(ffpModeActive, 1, "fast mode");
        ffp_programmer_model_i.send(CMD_SET_LOCK, 11'h7FF, ok);
        chk(ok, 1, "fast take");
        {ffpReadReq, debugReadReq} <= 2'b11;
        repeat (2) @(posedge clk);
        chk(ffpReadGrant, 1, "fast read");
        cmd(4'h8, 11'h0);
        repeat (3) @(posedge clk);
        chk({ffpReadGrant, debugReadGrant, ffpCmdRefused}, 1, "secure");
        apb(1'b0, 8'h08, 32'h0, 33'h0_8000_0000);
        {ffpReadReq, debugReadReq} <= 2'b00;
        ffp_programmer_model_i.erase_hold(20);
        waitdone();
        repeat (2) @(posedge clk);
        chk(securityActive, 0, "secure cleared");
        apb(1'b0, 8'h08, 32'h0, 33'h0);
        apb(1'b0, 8'h0C, 32'h0, 33'h0_0000_A500);
        $display("erase test done");
        give_verdict();
    end
endmodule // test_flash_lock_ctrl
